/* File: line_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-end receiver; it only listens, so it cannot stall the line
module line_rx_model #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk,
   input wire logic line,
   input wire logic oe,
   input wire logic nine,
   output logic [8:0] rx_word,
   output logic rx_stop,
   output int rx_count
);
   int i;
   initial begin
      rx_count = 0;
      rx_word = 9'h000;
      rx_stop = 1'b0;
      forever begin
         @(negedge clk);
         if (oe === 1'b1 && line === 1'b0) begin
            repeat (BIT_CLKS / 2) @(negedge clk);
            rx_word = 9'h000;
            for (i = 0; i < (nine ? 9 : 8); i++) begin
               repeat (BIT_CLKS) @(negedge clk);
               rx_word[i] = line;
            end
            repeat (BIT_CLKS) @(negedge clk);
            rx_stop = line;
            rx_count++;
            // A break keeps the line low; rearm only after the mark
            while (line !== 1'b1) @(negedge clk);
         end
      end
   end
endmodule
`default_nettype wire

/* File: serial_tx.sv */
// Contract
// (R1) Enabled and nothing pending: line held high
// (R2) Disabled: pin released to port function
// (R3) Frame: start, 8/9 bits LSB first, stop
// (R4) Start bit drives line low
// (R5) Stop bit drives line high
// (R6) Word-length bit picks 8 or 9; ninth separate
// (R7) Idle frame: whole frame of ones
// (R8) Break frames of zeros, then one mark
// (R9) Own transmit baud generator
// (R10) Up to 250K conventional, 500K extended
// (R11) Enable attaches pin, sends one idle frame
// (R12) Empty cleared by status access then write
// (R13) Empty set when word moves to shifter
// (R14) Empty irq when enabled and mask clear
// (R15) Write during frame waits for frame end
// (R16) Write while idle starts at once, empty set
// (R17) Frame end sets complete flag, irq; idle frame end leaves it unchanged
// (R18) Complete cleared by same access sequence
// (R19) Break repeats while bit set, mark after
// (R20) Eight-bit mode ignores ninth bit
`timescale 1ns/1ps
`default_nettype none
module serial_tx #(
   parameter int unsigned BUF_DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tx_enable_bit,
   input wire logic word_len_nine,
   input wire logic tx_ninth_bit,
   input wire logic send_break_bit,
   input wire serial_tx_pkg::baud_cfg_t baud_cfg,
   input wire logic status_reg_access,
   input wire logic data_reg_write,
   input wire logic [7:0] data_reg_wdata,
   output logic data_reg_ready,
   input wire logic tx_empty_irq_enable,
   input wire logic tx_complete_irq_enable,
   input wire logic cpu_irq_mask,
   output logic tx_buffer_empty_flag,
   output logic tx_complete_flag,
   output logic irq,
   output logic serial_tx_out,
   output logic serial_tx_oe,
   output logic tx_busy
);
   serial_tx_pkg::tx_state_t state_reg;
   serial_tx_pkg::tx_state_t state_next;
   serial_tx_pkg::tx_word_t wr_word;
   serial_tx_pkg::tx_word_t head_word;
   logic [10:0] shift_reg;
   logic [3:0] bits_left_reg;
   logic line_reg;
   logic oe_reg;
   logic empty_reg;
   logic complete_reg;
   logic armed_reg;
   logic run;
   logic tick;
   logic buf_valid;
   logic buf_pop;
   logic frame_end;
   logic load_word;
   logic load_break;
   logic clear_seq;
   logic accept;
   logic [3:0] frame_bits;

   // Start + data + stop, counted in bit periods
   function automatic logic [3:0] frame_len(input logic nine);
      frame_len = nine ?
         4'(serial_tx_pkg::DATA_BITS_LONG + 1 + serial_tx_pkg::STOP_BITS) :
         4'(serial_tx_pkg::DATA_BITS_SHORT + 1 + serial_tx_pkg::STOP_BITS);
   endfunction

   assign frame_bits = frame_len(word_len_nine);
   // Divider held at zero while waiting, so a start bit launched from
   // rest lasts a whole bit period instead of a partial one (see R4)
   assign run = tx_enable_bit && state_reg != serial_tx_pkg::ST_OFF
      && state_reg != serial_tx_pkg::ST_READY;

   tx_baud_gen u_baud (
      .clk(clk),
      .rst_n(rst_n),
      .run(run),
      .cfg(baud_cfg),
      .tick(tick)
   );

   // Ninth bit forced low in 8-bit mode so it never reaches the line
   assign wr_word.ninth = word_len_nine & tx_ninth_bit; // see R20
   assign wr_word.data = data_reg_wdata;
   assign accept = data_reg_write && data_reg_ready && tx_enable_bit;

   tx_skid_buffer #(
      .WIDTH(9),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .flush(!tx_enable_bit), // disabling drops held data
      .in_valid(data_reg_write && tx_enable_bit),
      .in_ready(data_reg_ready),
      .in_data(wr_word),
      .out_valid(buf_valid),
      .out_ready(buf_pop),
      .out_data(head_word)
   );

   // A frame boundary is the tick that finishes the last bit
   assign frame_end = tick && bits_left_reg == 4'h1;
   // Held word moves into the shifter at once from rest, otherwise only at a boundary (see R15)
   assign load_word = buf_valid && !send_break_bit
      && ((state_reg == serial_tx_pkg::ST_READY)
      || (frame_end && (state_reg == serial_tx_pkg::ST_FRAME
      || state_reg == serial_tx_pkg::ST_IDLE_FRAME
      || state_reg == serial_tx_pkg::ST_MARK)));
   assign load_break = send_break_bit
      && ((state_reg == serial_tx_pkg::ST_READY)
      || (frame_end && state_reg != serial_tx_pkg::ST_OFF));
   assign buf_pop = load_word;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         serial_tx_pkg::ST_OFF: begin
            if (tx_enable_bit) begin
               state_next = serial_tx_pkg::ST_IDLE_FRAME; // see R11
            end
         end
         serial_tx_pkg::ST_IDLE_FRAME, serial_tx_pkg::ST_FRAME,
         serial_tx_pkg::ST_MARK: begin
            if (load_break) begin
               state_next = serial_tx_pkg::ST_BREAK;
            end else if (load_word) begin
               state_next = serial_tx_pkg::ST_FRAME;
            end else if (frame_end) begin
               state_next = serial_tx_pkg::ST_READY;
            end
         end
         serial_tx_pkg::ST_READY: begin
            if (load_break) begin
               state_next = serial_tx_pkg::ST_BREAK;
            end else if (load_word) begin
               state_next = serial_tx_pkg::ST_FRAME; // see R16
            end
         end
         serial_tx_pkg::ST_BREAK: begin
            if (frame_end && send_break_bit) begin
               state_next = serial_tx_pkg::ST_BREAK; // see R19
            end else if (frame_end) begin
               state_next = serial_tx_pkg::ST_MARK; // see R8
            end
         end
         default: state_next = serial_tx_pkg::ST_OFF;
      endcase
      if (!tx_enable_bit) begin
         state_next = serial_tx_pkg::ST_OFF;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= serial_tx_pkg::ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // Shifter: bit 0 is on the line; ones fill in behind it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= '1;
         bits_left_reg <= 4'h0;
      end else if (!tx_enable_bit) begin
         shift_reg <= '1;
         bits_left_reg <= 4'h0;
      end else if (state_reg == serial_tx_pkg::ST_OFF) begin
         shift_reg <= '1; // see R7
         bits_left_reg <= frame_bits;
      end else if (load_break) begin
         shift_reg <= '0; // see R8
         bits_left_reg <= frame_bits;
      end else if (load_word) begin
         // see R3 R4 R5 R6
         if (word_len_nine) begin
            shift_reg <= {1'b1, head_word.ninth, head_word.data,
               serial_tx_pkg::LINE_SPACE};
         end else begin
            shift_reg <= {2'b11, head_word.data,
               serial_tx_pkg::LINE_SPACE};
         end
         bits_left_reg <= frame_bits;
      end else if (frame_end && state_reg == serial_tx_pkg::ST_BREAK) begin
         shift_reg <= '1; // single closing mark bit
         bits_left_reg <= 4'h1;
      end else if (tick && bits_left_reg != 4'h0) begin
         shift_reg <= {1'b1, shift_reg[10:1]};
         bits_left_reg <= bits_left_reg - 4'h1;
      end
   end

   // Line high whenever nothing is shifting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_reg <= serial_tx_pkg::LINE_IDLE;
      end else if (bits_left_reg == 4'h0 && !load_word && !load_break) begin
         line_reg <= serial_tx_pkg::LINE_IDLE; // see R1
      end else if (load_break) begin
         line_reg <= serial_tx_pkg::LINE_SPACE;
      end else if (load_word) begin
         line_reg <= serial_tx_pkg::LINE_SPACE; // see R4
      end else if (frame_end && state_reg == serial_tx_pkg::ST_BREAK) begin
         line_reg <= serial_tx_pkg::LINE_IDLE;
      end else if (tick) begin
         line_reg <= shift_reg[1];
      end else begin
         line_reg <= shift_reg[0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= tx_enable_bit; // see R2 R11
      end
   end

   assign serial_tx_out = line_reg;
   assign serial_tx_oe = oe_reg;
   assign tx_busy = bits_left_reg != 4'h0;

   // Status access arms the clear; the write that follows completes it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_reg <= 1'b0;
      end else if (status_reg_access) begin
         armed_reg <= 1'b1;
      end else if (data_reg_write) begin
         armed_reg <= 1'b0;
      end
   end

   assign clear_seq = armed_reg && accept; // see R12 R18

   // Hardware set skipped when a write is accepted in the same cycle, so a same-cycle clear wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         empty_reg <= serial_tx_pkg::EMPTY_RESET;
      end else if (load_word && !(accept && buf_valid)) begin
         empty_reg <= 1'b1; // see R13 R16
      end else if (clear_seq) begin
         empty_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         complete_reg <= serial_tx_pkg::COMPLETE_RESET;
      end else if (frame_end && (state_reg == serial_tx_pkg::ST_FRAME
            || state_reg == serial_tx_pkg::ST_BREAK)) begin
         complete_reg <= 1'b1; // see R17
      end else if (clear_seq) begin
         complete_reg <= 1'b0;
      end
   end

   assign tx_buffer_empty_flag = empty_reg;
   assign tx_complete_flag = complete_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         // see R14 R17
         irq <= !cpu_irq_mask && ((empty_reg && tx_empty_irq_enable)
            || (complete_reg && tx_complete_irq_enable));
      end
   end
endmodule
`default_nettype wire

/* File: serial_tx_pkg.sv */
package serial_tx_pkg;

   // Frame shape
   localparam int unsigned DATA_BITS_SHORT = 8;
   localparam int unsigned DATA_BITS_LONG = 9;
   localparam int unsigned STOP_BITS = 1;

   // Conventional generator: rate = f / (32 * pr * tr)
   localparam int unsigned CONV_BASE_DIV = 32;
   localparam int unsigned EXT_BASE_DIV = 16;
   localparam logic [1:0] PR_SEL_1 = 2'h0;
   localparam logic [1:0] PR_SEL_3 = 2'h1;
   localparam logic [1:0] PR_SEL_4 = 2'h2;
   localparam logic [1:0] PR_SEL_13 = 2'h3;
   localparam logic [3:0] PR_VAL_1 = 4'h1;
   localparam logic [3:0] PR_VAL_3 = 4'h3;
   localparam logic [3:0] PR_VAL_4 = 4'h4;
   localparam logic [3:0] PR_VAL_13 = 4'hd;

   // Top rates supported by the two generators
   localparam int unsigned MAX_CONV_BAUD = 250000;
   localparam int unsigned MAX_EXT_BAUD = 500000;

   // Clock and derived minimum bit time in cycles
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned MIN_BIT_CYCLES = (CLK_HZ + MAX_EXT_BAUD - 1)
      / MAX_EXT_BAUD;

   // Line levels and flag reset values
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_SPACE = 1'b0;
   localparam logic EMPTY_RESET = 1'b1;
   localparam logic COMPLETE_RESET = 1'b1;

   typedef enum logic [5:0] {
      ST_OFF = 6'h01,
      ST_IDLE_FRAME = 6'h02,
      ST_READY = 6'h04,
      ST_FRAME = 6'h08,
      ST_BREAK = 6'h10,
      ST_MARK = 6'h20
   } tx_state_t;

   // One word as it sits in the buffer
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } tx_word_t;

   // Rate setup
   typedef struct packed {
      logic [1:0] pr_sel;
      logic [2:0] tr_sel;
      logic [7:0] ext_div;
   } baud_cfg_t;

endpackage

/* File: serial_tx_props.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_tx_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tx_enable_bit,
   input wire logic data_reg_write,
   input wire logic tx_empty_irq_enable,
   input wire logic tx_complete_irq_enable,
   input wire logic cpu_irq_mask,
   input wire logic tx_buffer_empty_flag,
   input wire logic tx_complete_flag,
   input wire logic irq,
   input wire logic serial_tx_out,
   input wire logic serial_tx_oe,
   input wire logic tx_busy
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic want_irq;
   assign want_irq = !cpu_irq_mask &&
      ((tx_buffer_empty_flag && tx_empty_irq_enable) ||
       (tx_complete_flag && tx_complete_irq_enable));
   chk_irq_raise: assert property (want_irq |=> irq)
      else $error("irq missing");
   chk_irq_drop: assert property (!want_irq |=> !irq)
      else $error("irq without cause");
   chk_pin_release: assert property (!tx_enable_bit |=> !serial_tx_oe)
      else $error("pin still driven");
   chk_pin_attach: assert property (
      $past(tx_enable_bit) && tx_enable_bit |-> serial_tx_oe)
      else $error("pin not attached");
   chk_idle_high: assert property (
      tx_enable_bit && serial_tx_oe && !tx_busy |-> serial_tx_out)
      else $error("idle line low");
   // A bit lasts 16 clocks at the tested rate, so 8 is a safe lower bound
   chk_low_bit_hold: assert property (
      $fell(serial_tx_out) && tx_enable_bit |-> !serial_tx_out [*8])
      else $error("low bit too short");
   chk_high_bit_hold: assert property (
      $rose(serial_tx_out) && tx_enable_bit |-> serial_tx_out [*8])
      else $error("high bit too short");
   chk_empty_clear: assert property (
      $fell(tx_buffer_empty_flag) |-> $past(data_reg_write))
      else $error("empty flag cleared without write");
   chk_done_clear: assert property (
      $fell(tx_complete_flag) |-> $past(data_reg_write))
      else $error("complete flag cleared without write");
endmodule
`default_nettype wire

/* File: serial_tx_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_tx_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tx_enable_bit = 1'b0;
   logic word_len_nine = 1'b0;
   logic tx_ninth_bit = 1'b0;
   logic send_break_bit = 1'b0;
   serial_tx_pkg::baud_cfg_t baud_cfg = 13'h0001;
   logic status_reg_access = 1'b0;
   logic data_reg_write = 1'b0;
   logic [7:0] data_reg_wdata = 8'h00;
   logic tx_empty_irq_enable = 1'b0;
   logic tx_complete_irq_enable = 1'b1;
   logic cpu_irq_mask = 1'b1;
   logic data_reg_ready, tx_buffer_empty_flag, tx_complete_flag, irq;
   logic serial_tx_out, serial_tx_oe, tx_busy, rx_stop, ok;
   logic [8:0] rx_word;
   int rx_count, k, acc;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   serial_tx uut (.clk, .rst_n, .tx_enable_bit, .word_len_nine,
      .tx_ninth_bit, .send_break_bit, .baud_cfg, .status_reg_access,
      .data_reg_write, .data_reg_wdata, .data_reg_ready,
      .tx_empty_irq_enable, .tx_complete_irq_enable, .cpu_irq_mask,
      .tx_buffer_empty_flag, .tx_complete_flag, .irq, .serial_tx_out,
      .serial_tx_oe, .tx_busy);
   line_rx_model rx (.clk, .line(serial_tx_out), .oe(serial_tx_oe),
      .nine(word_len_nine), .rx_word, .rx_stop, .rx_count);
   task automatic chk(input string what, input logic [8:0] exp,
         input logic [8:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] d);
      status_reg_access = 1'b1;
      tick(1);
      status_reg_access = 1'b0;
      data_reg_write = 1'b1;
      data_reg_wdata = d;
      tick(1);
      data_reg_write = 1'b0;
   endtask
   task automatic wait_rx(input int n);
      int t;
      t = 0;
      while (rx_count < n && t < 600) begin
         tick(1);
         t++;
      end
      chk("frame count", 9'(n), 9'(rx_count));
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      tick(4);
      rst_n = 1'b1;
      chk("reset outputs", 9'h033, {3'h0, tx_buffer_empty_flag,
         tx_complete_flag, irq, serial_tx_oe, serial_tx_out, data_reg_ready});
      $display("test reset done");
      tx_enable_bit = 1'b1;
      ok = 1'b1;
      for (k = 0; k < 170; k++) begin
         tick(1);
         if (serial_tx_out !== 1'b1 || (k > 0 && serial_tx_oe !== 1'b1))
            ok = 1'b0;
      end
      chk("idle frame", 9'h001, 9'(ok));
      tick(30);
      $display("test enable done");
      // Ninth bit 0 lands in the stop slot if it were wrongly sent
      wr(8'ha5);
      tick(3);
      chk("flags after write", 9'h002, 9'({tx_buffer_empty_flag,
         tx_complete_flag}));
      wait_rx(1);
      chk("word", 9'h0a5, rx_word);
      chk("stop", 9'h001, 9'(rx_stop));
      tick(12);
      chk("masked", 9'h002, 9'({tx_complete_flag, irq}));
      cpu_irq_mask = 1'b0;
      tick(2);
      chk("complete irq", 9'h001, 9'(irq));
      tx_complete_irq_enable = 1'b0;
      tick(2);
      chk("irq off", 9'h000, 9'(irq));
      tx_empty_irq_enable = 1'b1;
      tick(2);
      chk("empty irq", 9'h001, 9'(irq));
      tx_empty_irq_enable = 1'b0;
      $display("test eight bit done");
      word_len_nine = 1'b1;
      tx_ninth_bit = 1'b1;
      acc = 0;
      while (data_reg_ready === 1'b1 && acc < 5) begin
         wr(8'h30 + 8'(acc));
         acc++;
      end
      chk("accepted", 9'h003, 9'(acc));
      data_reg_write = 1'b1;
      data_reg_wdata = 8'hff;
      tick(1);
      data_reg_write = 1'b0;
      for (k = 0; k < 3; k++) begin
         wait_rx(2 + k);
         chk("word", 9'h130 + 9'(k), rx_word);
         chk("stop", 9'h001, 9'(rx_stop));
      end
      tick(12);
      chk("flags drained", 9'h003, 9'({tx_buffer_empty_flag,
         tx_complete_flag}));
      tick(200);
      chk("refused write", 9'h004, 9'(rx_count));
      $display("test nine bit done");
      word_len_nine = 1'b0;
      send_break_bit = 1'b1;
      wait_rx(5);
      send_break_bit = 1'b0;
      chk("break", 9'h000, {rx_word[7:0], rx_stop});
      k = 0;
      while (tx_busy !== 1'b0 && k < 600) begin
         tick(1);
         k++;
      end
      tick(20);
      chk("after break", 9'h003, 9'({serial_tx_out,
         tx_complete_flag}));
      k = rx_count;
      wr(8'h5a);
      wait_rx(k + 1);
      chk("word after break", 9'h05a, rx_word);
      $display("test break done");
      tx_enable_bit = 1'b0;
      tick(2);
      chk("pin released", 9'h000, 9'(serial_tx_oe));
      $display("test disable done");
      wrap_up();
   end
endmodule
bind serial_tx serial_tx_props chk_i (.clk(clk), .rst_n(rst_n),
   .tx_enable_bit(tx_enable_bit), .data_reg_write(data_reg_write),
   .tx_empty_irq_enable(tx_empty_irq_enable),
   .tx_complete_irq_enable(tx_complete_irq_enable),
   .cpu_irq_mask(cpu_irq_mask), .tx_buffer_empty_flag(tx_buffer_empty_flag),
   .tx_complete_flag(tx_complete_flag), .irq(irq),
   .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe),
   .tx_busy(tx_busy));
`default_nettype wire

/* File: tx_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// Bit tick generator for the transmit side only; its count and rate
// are private to this one instance in serial_tx.
module tx_baud_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire serial_tx_pkg::baud_cfg_t cfg,
   output logic tick
);
   logic [15:0] count_reg;
   logic [15:0] limit;

   function automatic logic [3:0] pr_value(input logic [1:0] sel);
      case (sel)
         serial_tx_pkg::PR_SEL_1: pr_value = serial_tx_pkg::PR_VAL_1;
         serial_tx_pkg::PR_SEL_3: pr_value = serial_tx_pkg::PR_VAL_3;
         serial_tx_pkg::PR_SEL_4: pr_value = serial_tx_pkg::PR_VAL_4;
         default: pr_value = serial_tx_pkg::PR_VAL_13;
      endcase
   endfunction

   // Extended prescaler wins whenever it is nonzero (see R10)
   always_comb begin
      if (cfg.ext_div != 8'h00) begin
         limit = 16'(serial_tx_pkg::EXT_BASE_DIV) * {8'h00, cfg.ext_div};
      end else begin
         limit = (16'(serial_tx_pkg::CONV_BASE_DIV)
            * {12'h000, pr_value(cfg.pr_sel)}) << cfg.tr_sel;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin // see R9
      if (!rst_n) begin
         count_reg <= 16'h0000;
      end else if (!run || count_reg >= limit - 16'h0001) begin
         count_reg <= 16'h0000;
      end else begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   assign tick = run && (count_reg >= limit - 16'h0001);
endmodule
`default_nettype wire

/* File: tx_skid_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer in front of the shifter; a stalled shifter fills it
// and the upstream ready drops instead of a word being overwritten.
module tx_skid_buffer #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid = cnt_reg != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_reg[rd_reg];

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else if (flush) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= bump(wr_reg);
         end
         if (pop) begin
            rd_reg <= bump(rd_reg);
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire
